// ---- hdl/dmc_pkg.sv ----
package dmc_pkg;
    // register indices
    localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
    localparam logic [6:0] IDX_MUTE_CTRL = 7'h12;
    localparam logic [6:0] IDX_DAC_CTRL = 7'h13;
    localparam logic [6:0] IDX_FMT_CTRL = 7'h14;
    localparam logic [6:0] IDX_ZERO_CTRL = 7'h16;
    // reset values
    localparam logic [7:0] ATTEN_RESET = 8'hff;
    localparam logic [7:0] MUTE_CTRL_RESET = 8'h00;
    localparam logic [7:0] DAC_CTRL_RESET = 8'h00;
    localparam logic [7:0] FMT_CTRL_RESET = 8'h05;
    localparam logic [7:0] ZERO_CTRL_RESET = 8'h00;
    // writable bit masks, reserved positions held at zero
    localparam logic [7:0] MUTE_CTRL_MASK = 8'hc3;
    localparam logic [7:0] DAC_CTRL_MASK = 8'h73;
    localparam logic [7:0] FMT_CTRL_MASK = 8'h27;
    localparam logic [7:0] ZERO_CTRL_MASK = 8'h07;
    // field positions
    localparam int SOFT_RESET_BIT = 7;
    localparam int OVERSAMPLE_BIT = 6;
    localparam int RIGHT_MUTE_BIT = 1;
    localparam int LEFT_MUTE_BIT = 0;
    localparam int DEEMPH_RATE_LSB = 5;
    localparam int DEEMPH_EN_BIT = 4;
    localparam int RIGHT_DAC_BIT = 1;
    localparam int LEFT_DAC_BIT = 0;
    localparam int FILTER_BIT = 5;
    localparam int ZERO_COMMON_BIT = 2;
    localparam int ZERO_POL_BIT = 1;
    localparam int PHASE_BIT = 0;
    // attenuator: codes at or below this are mute
    localparam logic [7:0] ATTEN_MUTE_MAX = 8'h80;
    // word and ramp timing
    localparam int WORD_BITS = 16;
    localparam int RAMP_SAMPLES = 8;
endpackage

// ---- hdl/dmc_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1: attenuator spans 0 dB to -63 dB in 0.5 dB steps, plus mute
// RQ2: applied level steps one code per 8 sample periods toward target
// RQ3: attenuation dB equals 0.5 times code minus 255
// RQ4: codes 0 through 128 give full mute
// RQ5: attenuation codes reset to 255, meaning 0 dB
// RQ6: left and right attenuators are independent
// RQ7: word holds zero, 7-bit index, data byte; indices 10h-14h and 16h
// RQ8: host writes zero to reserved bits
// RQ9: register 12h holds soft reset, oversample, right and left mute
// RQ10: register 13h bits 1 and 0 disable right and left DAC
// RQ11: register 13h holds de-emphasis enable bit 4, rate bits 6:5
// RQ12: register 14h bits 2:0 select audio format, reset left-justified
// RQ13: register 14h bit 5 selects filter rolloff, reset sharp
// RQ14: register 16h bit 2 selects common zero flag, reset independent
// RQ15: register 16h bit 1 flag polarity, bit 0 output phase
// RQ16: registers 10h and 11h hold left and right attenuation codes
// RQ17: each write is 16 bits, msb first
// RQ18: latch low, sixteen clocks, latch rising edge commits the word
// RQ19: soft reset bit restores every register to default
// RQ20: soft mute ramps to mute and back at one step per 8 samples
// RQ21: writes to undefined indices are ignored
// RQ22: data sampled on bit clock rising edge while latch is low
module dmc_regs #(
    parameter int RAMP_SAMPLES = dmc_pkg::RAMP_SAMPLES
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // serial control port
    input wire logic ctrl_latch_i,
    input wire logic ctrl_bit_clock_i,
    input wire logic ctrl_serial_data_i,
    // sample rate strobe from the audio side, one pulse per sample
    input wire logic sample_tick_i,
    // applied attenuation codes, 128 means mute
    output logic [7:0] left_level_o,
    output logic [7:0] right_level_o,
    output logic left_muted_o,
    output logic right_muted_o,
    // mode controls
    output logic oversample_sel_o,
    output logic left_dac_disable_o,
    output logic right_dac_disable_o,
    output logic deemph_enable_o,
    output logic [1:0] deemph_rate_sel_o,
    output logic [2:0] audio_format_sel_o,
    output logic filter_rolloff_sel_o,
    output logic zero_flag_common_sel_o,
    output logic zero_flag_polarity_sel_o,
    output logic output_phase_sel_o
);
    // elaboration check: the ramp divider counts in eight bits
    if (RAMP_SAMPLES < 1 || RAMP_SAMPLES > 255) begin : g_ramp_range
        $error("RAMP_SAMPLES out of range");
    end

    // two-flop synchronisers for the asynchronous port pins
    logic [2:0] sync1_q, sync2_q;
    logic latch_prev_q, clk_prev_q;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            latch_prev_q <= 1'b1;
            clk_prev_q <= 1'b1;
        end else begin
            sync1_q <= {ctrl_latch_i, ctrl_bit_clock_i, ctrl_serial_data_i};
            sync2_q <= sync1_q;
            latch_prev_q <= sync2_q[2];
            clk_prev_q <= sync2_q[1];
        end
    end

    logic latch_s, bclk_s, data_s, bclk_rise, latch_rise;
    assign latch_s = sync2_q[2];
    assign bclk_s = sync2_q[1];
    assign data_s = sync2_q[0];
    assign bclk_rise = bclk_s && !clk_prev_q;
    assign latch_rise = latch_s && !latch_prev_q;

    // shift register and bit count; bit clock needs >= 3 mclk per phase
    logic [15:0] shift_q, shift_d;
    logic [4:0] count_q, count_d;
    always_comb begin
        shift_d = shift_q;
        count_d = count_q;
        if (latch_s) begin
            count_d = 5'h00;
        end else if (bclk_rise) begin
            shift_d = {shift_q[14:0], data_s}; // RQ22 RQ17
            if (count_q != 5'h1f) begin
                count_d = count_q + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_q <= 16'h0000;
            count_q <= 5'h00;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    // a word commits only after exactly sixteen clocks and msb zero
    logic commit;
    logic [6:0] widx;
    logic [7:0] wdata;
    assign widx = shift_q[14:8];
    assign wdata = shift_q[7:0];
    assign commit = latch_rise && count_q == 5'(dmc_pkg::WORD_BITS) && !shift_q[15]; // RQ18 RQ7

    // control register bank
    logic [7:0] latt_q, latt_d, ratt_q, ratt_d;
    logic [7:0] mute_q, mute_d, dac_q, dac_d, fmt_q, fmt_d, zero_q, zero_d;
    always_comb begin
        latt_d = latt_q;
        ratt_d = ratt_q;
        mute_d = mute_q;
        dac_d = dac_q;
        fmt_d = fmt_q;
        zero_d = zero_q;
        if (mute_q[dmc_pkg::SOFT_RESET_BIT]) begin
            // soft reset: restore defaults, bit itself clears
            latt_d = dmc_pkg::ATTEN_RESET; // RQ19
            ratt_d = dmc_pkg::ATTEN_RESET;
            mute_d = dmc_pkg::MUTE_CTRL_RESET;
            dac_d = dmc_pkg::DAC_CTRL_RESET;
            fmt_d = dmc_pkg::FMT_CTRL_RESET;
            zero_d = dmc_pkg::ZERO_CTRL_RESET;
        end else if (commit) begin
            // reserved bits masked off so test modes never engage
            case (widx)
                dmc_pkg::IDX_LEFT_ATTEN: latt_d = wdata; // RQ16 RQ6
                dmc_pkg::IDX_RIGHT_ATTEN: ratt_d = wdata; // RQ16 RQ6
                dmc_pkg::IDX_MUTE_CTRL: mute_d = wdata & dmc_pkg::MUTE_CTRL_MASK; // RQ9 RQ8
                dmc_pkg::IDX_DAC_CTRL: dac_d = wdata & dmc_pkg::DAC_CTRL_MASK; // RQ10 RQ11
                dmc_pkg::IDX_FMT_CTRL: fmt_d = wdata & dmc_pkg::FMT_CTRL_MASK; // RQ12 RQ13
                dmc_pkg::IDX_ZERO_CTRL: zero_d = wdata & dmc_pkg::ZERO_CTRL_MASK; // RQ14 RQ15
                default: begin
                end // RQ21
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latt_q <= dmc_pkg::ATTEN_RESET; // RQ5
            ratt_q <= dmc_pkg::ATTEN_RESET;
            mute_q <= dmc_pkg::MUTE_CTRL_RESET;
            dac_q <= dmc_pkg::DAC_CTRL_RESET;
            fmt_q <= dmc_pkg::FMT_CTRL_RESET;
            zero_q <= dmc_pkg::ZERO_CTRL_RESET;
        end else begin
            latt_q <= latt_d;
            ratt_q <= ratt_d;
            mute_q <= mute_d;
            dac_q <= dac_d;
            fmt_q <= fmt_d;
            zero_q <= zero_d;
        end
    end

    // ramp interval divider: one enable pulse per RAMP_SAMPLES samples
    logic [7:0] div_q, div_d;
    logic step_q, step_d;
    always_comb begin
        div_d = div_q;
        step_d = 1'b0;
        if (sample_tick_i) begin
            if (div_q == 8'(RAMP_SAMPLES - 1)) begin
                div_d = 8'h00;
                step_d = 1'b1; // RQ2
            end else begin
                div_d = div_q + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_q <= 8'h00;
            step_q <= 1'b0;
        end else begin
            div_q <= div_d;
            step_q <= step_d;
        end
    end

    // clamp a code to the mute floor; all codes up to 128 mean mute
    function automatic logic [7:0] eff_target(input logic [7:0] code, input logic mute);
        if (mute || code <= dmc_pkg::ATTEN_MUTE_MAX) begin
            eff_target = dmc_pkg::ATTEN_MUTE_MAX; // RQ4 RQ20
        end else begin
            eff_target = code; // RQ3 RQ1
        end
    endfunction

    // one code step toward the target; code step is 0.5 dB
    function automatic logic [7:0] ramp_step(input logic [7:0] cur, input logic [7:0] tgt);
        if (cur < tgt) begin
            ramp_step = cur + 8'h01;
        end else if (cur > tgt) begin
            ramp_step = cur - 8'h01;
        end else begin
            ramp_step = cur;
        end
    endfunction

    logic [7:0] ltgt, rtgt;
    assign ltgt = eff_target(latt_q, mute_q[dmc_pkg::LEFT_MUTE_BIT]);
    assign rtgt = eff_target(ratt_q, mute_q[dmc_pkg::RIGHT_MUTE_BIT]);

    // applied levels, each channel ramps on its own
    logic [7:0] llev_q, llev_d, rlev_q, rlev_d;
    logic lmute_q, lmute_d, rmute_q, rmute_d;
    always_comb begin
        llev_d = llev_q;
        rlev_d = rlev_q;
        if (mute_q[dmc_pkg::SOFT_RESET_BIT]) begin
            llev_d = dmc_pkg::ATTEN_RESET;
            rlev_d = dmc_pkg::ATTEN_RESET;
        end else if (step_q) begin
            llev_d = ramp_step(llev_q, ltgt); // RQ2 RQ6
            rlev_d = ramp_step(rlev_q, rtgt); // RQ2 RQ6
        end
        // flags built from the next level so they flip in the same cycle
        lmute_d = llev_d <= dmc_pkg::ATTEN_MUTE_MAX; // RQ4
        rmute_d = rlev_d <= dmc_pkg::ATTEN_MUTE_MAX; // RQ4
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            llev_q <= dmc_pkg::ATTEN_RESET;
            rlev_q <= dmc_pkg::ATTEN_RESET;
            lmute_q <= 1'b0;
            rmute_q <= 1'b0;
        end else begin
            llev_q <= llev_d;
            rlev_q <= rlev_d;
            lmute_q <= lmute_d;
            rmute_q <= rmute_d;
        end
    end

    // outputs straight from flops
    assign left_level_o = llev_q;
    assign right_level_o = rlev_q;
    assign left_muted_o = lmute_q;
    assign right_muted_o = rmute_q;
    assign oversample_sel_o = mute_q[dmc_pkg::OVERSAMPLE_BIT];
    assign left_dac_disable_o = dac_q[dmc_pkg::LEFT_DAC_BIT];
    assign right_dac_disable_o = dac_q[dmc_pkg::RIGHT_DAC_BIT];
    assign deemph_enable_o = dac_q[dmc_pkg::DEEMPH_EN_BIT];
    assign deemph_rate_sel_o = dac_q[dmc_pkg::DEEMPH_RATE_LSB +: 2];
    assign audio_format_sel_o = fmt_q[2:0];
    assign filter_rolloff_sel_o = fmt_q[dmc_pkg::FILTER_BIT];
    assign zero_flag_common_sel_o = zero_q[dmc_pkg::ZERO_COMMON_BIT];
    assign zero_flag_polarity_sel_o = zero_q[dmc_pkg::ZERO_POL_BIT];
    assign output_phase_sel_o = zero_q[dmc_pkg::PHASE_BIT];

    // assertions
    level_step_one_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        $changed(llev_q) && !$past(mute_q[7]) |-> $past(step_q)) // RQ2
        else $error("left level moved without ramp step");
    level_toward_target_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        step_q && !mute_q[7] && llev_q < ltgt |=> llev_q == $past(llev_q) + 8'h01) // RQ2
        else $error("left level did not step up by one");
    mute_floor_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        llev_q >= dmc_pkg::ATTEN_MUTE_MAX && rlev_q >= dmc_pkg::ATTEN_MUTE_MAX) // RQ4 RQ1
        else $error("level below mute floor");
    bad_index_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        commit && !mute_q[7] && widx == 7'h15 |=> $stable(latt_q) && $stable(fmt_q)) // RQ21
        else $error("undefined index changed a register");
    left_write_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        commit && !mute_q[7] && widx == dmc_pkg::IDX_LEFT_ATTEN
        |=> latt_q == $past(wdata) && $stable(ratt_q)) // RQ16
        else $error("left attenuation write failed");
    soft_reset_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        mute_q[7] |=> fmt_q == dmc_pkg::FMT_CTRL_RESET && latt_q == dmc_pkg::ATTEN_RESET
        && !mute_q[7]) // RQ19
        else $error("soft reset did not restore defaults");
    reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (zero_q & ~dmc_pkg::ZERO_CTRL_MASK) == 8'h00
        && (fmt_q & ~dmc_pkg::FMT_CTRL_MASK) == 8'h00) // RQ8
        else $error("reserved bit set");
    short_word_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        latch_rise && count_q != 5'h10 |=> $stable(latt_q) && $stable(dac_q)) // RQ18
        else $error("short word committed");
    shift_sample_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        bclk_rise && !latch_s |=> shift_q[0] == $past(data_s)) // RQ22
        else $error("bit not captured");
    muted_flag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        left_muted_o == (llev_q <= dmc_pkg::ATTEN_MUTE_MAX) && right_muted_o == (rlev_q == 8'h80)) // RQ4
        else $error("mute flag disagrees with level");
    right_step_down_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        step_q && !mute_q[7] && rlev_q > rtgt |=> rlev_q == $past(rlev_q) - 8'h01) // RQ2
        else $error("right level did not step down by one");

    write_seen_c: cover property (@(posedge mclk_i) commit);
    mute_ramp_c: cover property (@(posedge mclk_i) left_muted_o && mute_q[0]);
    soft_reset_c: cover property (@(posedge mclk_i) mute_q[7]);
    short_word_c: cover property (@(posedge mclk_i) latch_rise && count_q != 5'h10);
endmodule
`default_nettype wire

// ---- tb/dmc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side of the three-wire control port, bit clock period 400 ns
module dmc_host (
    // system clock, only used to pick a start time
    input wire logic mclk_i,
    // control port pins
    output logic ctrl_latch_o,
    output logic ctrl_bit_clock_o,
    output logic ctrl_serial_data_o
);
    // idle: latch high, bit clock parked low between frames
    initial begin
        ctrl_latch_o = 1'b1;
        ctrl_bit_clock_o = 1'b0;
        ctrl_serial_data_o = 1'b0;
    end

    // msb first; nbits below 16 makes a cut frame the device must drop
    task automatic send_word(input logic [15:0] w, input int nbits);
        @(posedge mclk_i);
        #1;
        ctrl_latch_o = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            ctrl_serial_data_o = w[i];
            #200;
            ctrl_bit_clock_o = 1'b1;
            #200;
            ctrl_bit_clock_o = 1'b0;
        end
        // commit edge; data no longer held, so show its inverse
        ctrl_latch_o = 1'b1;
        ctrl_serial_data_o = ~w[0];
        #400;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int RAMP = 2;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sample_tick_i = 1'b0;
    logic ctrl_latch, ctrl_bit_clock, ctrl_serial_data;
    logic [7:0] left_level, right_level;
    logic left_muted, right_muted, oversample_sel, left_dac_disable, right_dac_disable;
    logic deemph_enable, filter_rolloff_sel, zero_flag_common_sel, zero_flag_polarity_sel;
    logic output_phase_sel;
    logic [1:0] deemph_rate_sel;
    logic [2:0] audio_format_sel;
    logic [7:0] r12, r13, r14, r16, ll, rl, d;
    logic [6:0] idx;
    logic [6:0] idxs [4] = '{7'h12, 7'h13, 7'h14, 7'h16};
    logic [30:0] exp_q [$];
    logic [30:0] e;
    wire logic [30:0] seen;
    logic chk = 1'b0;
    logic [31:0] lfsr = 32'h49e14dbf;
    int bad_count = 0;
    int n_compared = 0;

    always #25 mclk_i = ~mclk_i;

    dmc_host host (.mclk_i(mclk_i), .ctrl_latch_o(ctrl_latch),
        .ctrl_bit_clock_o(ctrl_bit_clock), .ctrl_serial_data_o(ctrl_serial_data));

    dmc_regs #(.RAMP_SAMPLES(RAMP)) uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .ctrl_latch_i(ctrl_latch), .ctrl_bit_clock_i(ctrl_bit_clock),
        .ctrl_serial_data_i(ctrl_serial_data), .sample_tick_i(sample_tick_i),
        .left_level_o(left_level), .right_level_o(right_level),
        .left_muted_o(left_muted), .right_muted_o(right_muted),
        .oversample_sel_o(oversample_sel), .left_dac_disable_o(left_dac_disable),
        .right_dac_disable_o(right_dac_disable), .deemph_enable_o(deemph_enable),
        .deemph_rate_sel_o(deemph_rate_sel), .audio_format_sel_o(audio_format_sel),
        .filter_rolloff_sel_o(filter_rolloff_sel),
        .zero_flag_common_sel_o(zero_flag_common_sel),
        .zero_flag_polarity_sel_o(zero_flag_polarity_sel),
        .output_phase_sel_o(output_phase_sel));

    // every output in one vector so a single compare covers them all
    assign seen = {left_level, right_level, left_muted, right_muted, oversample_sel,
        left_dac_disable, right_dac_disable, deemph_enable, deemph_rate_sel,
        audio_format_sel, filter_rolloff_sel, zero_flag_common_sel,
        zero_flag_polarity_sel, output_phase_sel};

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [30:0] pack_exp();
        return {ll, rl, ll == 8'h80, rl == 8'h80, r12[6], r13[0], r13[1], r13[4],
            r13[6:5], r14[2:0], r14[5], r16[2], r16[1], r16[0]};
    endfunction

    // bench copy of the power-on state
    task automatic set_defaults();
        r12 = 8'h00;
        r13 = 8'h00;
        r14 = 8'h05;
        r16 = 8'h00;
        ll = 8'hff;
        rl = 8'hff;
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // note the expectation; the monitor compares at the next edge
    task automatic check();
        exp_q.push_back(pack_exp());
        chk = 1'b1;
        @(posedge mclk_i);
        #1 chk = 1'b0;
    endtask

    // one serial word; bench model ignores refused words
    task automatic wr(input logic [15:0] w);
        host.send_word(w, 16);
        if (!w[15]) begin
            case (w[14:8])
                7'h12: r12 = w[7:0] & dmc_pkg::MUTE_CTRL_MASK;
                7'h13: r13 = w[7:0] & dmc_pkg::DAC_CTRL_MASK;
                7'h14: r14 = w[7:0] & dmc_pkg::FMT_CTRL_MASK;
                7'h16: r16 = w[7:0] & dmc_pkg::ZERO_CTRL_MASK;
                default: ;
            endcase
            if (w[14:8] == 7'h12 && w[7]) begin
                set_defaults();
            end
        end
        repeat (6) @(posedge mclk_i);
        #1;
    endtask

    // whole steps only, so the tick divider phase is the same at every write
    task automatic tick(input int steps);
        repeat (steps * RAMP) begin
            sample_tick_i = 1'b1;
            @(posedge mclk_i);
            #1 sample_tick_i = 1'b0;
            @(posedge mclk_i);
            #1;
        end
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    // oldest note against what the outputs show now
    always @(posedge mclk_i) begin
        if (chk) begin
            n_compared++;
            e = exp_q.pop_front();
            if (e !== seen) begin
                bad_count++;
                $display("[ERR] outputs expected %h seen %h", e, seen);
            end
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge mclk_i);
        bad_count++;
        $display("[ERR] run length expected finish seen timeout");
        end_sim();
    end

    initial begin
        set_defaults();
        repeat (6) @(posedge mclk_i);
        #1 reset_n_i = 1'b1;
        @(posedge mclk_i);
        #1;
        check();
        // random bytes with reserved bits set; soft reset kept clear here
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            idx = idxs[k % 4];
            d = lfsr[7:0];
            if (idx == 7'h12) begin
                d[7] = 1'b0;
            end
            wr({1'b0, idx, d});
            check();
        end
        wr(16'h15ff);
        check();
        wr(16'h9400);
        check();
        // fifteen clocks only: the word must be dropped
        wr(16'h1300);
        host.send_word(16'h1373, 15);
        repeat (6) @(posedge mclk_i);
        #1;
        check();
        wr(16'h1200);
        wr(16'h10fd);
        check();
        tick(1);
        ll = 8'hfe;
        check();
        tick(1);
        ll = 8'hfd;
        check();
        tick(2);
        check();
        wr(16'h1181);
        tick(126);
        rl = 8'h81;
        check();
        wr(16'h1180);
        tick(1);
        rl = 8'h80;
        check();
        wr(16'h1105);
        tick(2);
        check();
        wr(16'h1201);
        tick(125);
        ll = 8'h80;
        check();
        wr(16'h1200);
        tick(125);
        ll = 8'hfd;
        check();
        wr(16'h1680);
        wr(16'h1280);
        check();
        repeat (2) @(posedge mclk_i);
        end_sim();
    end
endmodule
`default_nettype wire
